// File: src/dpmc_top.sv
`timescale 1ns/1ps
module dpmc_top (
    input  wire logic  core_clk,
    input  wire logic  srst,
    input  wire logic  ce,
    // Byte register port
    input  wire logic  [7:0]  reg_addr,
    input  wire logic         reg_wr,
    input  wire logic  [7:0]  reg_wdata,
    input  wire logic         reg_rd,
    output logic       [7:0]  reg_rdata,
    output logic              reg_rvalid,
    // Reference monitor results and loop lock, same clock
    input  wire logic         signal_loss_monitor,
    input  wire logic         single_cycle_monitor,
    input  wire logic         coarse_freq_monitor,
    input  wire logic         guard_timer_monitor,
    input  wire logic         loop_locked,
    // Loop control outputs
    output logic       [25:0] slope_limit_ps,
    output logic              slope_unlimited,
    output logic       [19:0] loop_bw_mhz,
    output logic              realign_pulse,
    output logic              use_reference,
    output logic              use_oscillator_input,
    output logic              holdover_active,
    output logic              locked_active,
    output logic       [7:0]  phase_mem_code,
    output logic       [7:0]  monitor_limits,
    output dpmc_pkg::dpmc_mode_t mode_applied
);
    import dpmc_pkg::*;

    typedef enum logic [1:0] {
        ST_FREERUN,
        ST_ACQUIRE,
        ST_LOCKED,
        ST_HOLDOVER
    } dpmc_state_t;

    // Register file
    dpmc_wr_if wr_bus ();

    logic [7:0] loop_control;
    logic [7:0] operating_mode_select;
    logic [7:0] failure_holdover_gate;
    logic [7:0] lock_holdover_flags_r;
    logic [7:0] lock_holdover_flags_nxt;
    logic [7:0] phase_memory_limit_code;
    logic [7:0] monitor_limit_select;

    wire hit_loop  = reg_addr == OFS_LOOP_CTRL;
    wire hit_mode  = reg_addr == OFS_MODE_SEL;
    wire hit_gate  = reg_addr == OFS_FAIL_GATE;
    wire hit_flags = reg_addr == OFS_FLAGS;
    wire hit_pmem  = reg_addr == OFS_PHASE_MEM;
    wire hit_mon   = reg_addr == OFS_MON_LIMIT;

    assign wr_bus.ce      = ce;
    assign wr_bus.wr_data = reg_wdata;
    assign wr_bus.wr_sel[WI_LOOP] = reg_wr && hit_loop;
    assign wr_bus.wr_sel[WI_MODE] = reg_wr && hit_mode;
    assign wr_bus.wr_sel[WI_GATE] = reg_wr && hit_gate;
    assign wr_bus.wr_sel[WI_PMEM] = reg_wr && hit_pmem;
    assign wr_bus.wr_sel[WI_MON]  = reg_wr && hit_mon;

    dpmc_reg_byte #(.IDX(WI_LOOP), .RESET_VAL(RST_LOOP_CTRL)) u_loop (
        .core_clk (core_clk),
        .srst     (srst),
        .wr       (wr_bus.dst),
        .value    (loop_control)
    );
    dpmc_reg_byte #(.IDX(WI_MODE), .RESET_VAL(RST_MODE_SEL)) u_mode (
        .core_clk (core_clk),
        .srst     (srst),
        .wr       (wr_bus.dst),
        .value    (operating_mode_select)
    );
    dpmc_reg_byte #(.IDX(WI_GATE), .RESET_VAL(RST_FAIL_GATE)) u_gate (
        .core_clk (core_clk),
        .srst     (srst),
        .wr       (wr_bus.dst),
        .value    (failure_holdover_gate)
    );
    // Code is computed by software; held and passed on unchanged
    dpmc_reg_byte #(.IDX(WI_PMEM), .RESET_VAL(RST_PHASE_MEM)) u_pmem (
        .core_clk (core_clk),
        .srst     (srst),
        .wr       (wr_bus.dst),
        .value    (phase_memory_limit_code)
    );
    dpmc_reg_byte #(.IDX(WI_MON), .RESET_VAL(RST_MON_LIMIT)) u_mon (
        .core_clk (core_clk),
        .srst     (srst),
        .wr       (wr_bus.dst),
        .value    (monitor_limit_select)
    );

    // Field decode
    wire [1:0] slope_code = loop_control[SLOPE_LSB +: 2];
    wire [2:0] bw_code    = loop_control[BW_LSB +: 3];
    wire [1:0] mode_code  = operating_mode_select[MODE_LSB +: 2];
    wire [3:0] gate_bits  = failure_holdover_gate[GATE_LSB +: 4];

    // Realign acts on each write of a one, not on the stored level
    wire realign_req = wr_bus.wr_sel[WI_LOOP] && reg_wdata[REALIGN_BIT]; // R2

    logic [25:0] slope_ps_w;
    logic        slope_unl_w;
    always_comb begin
        slope_unl_w = 1'b0;
        unique case (slope_code) // R1
            2'h0: slope_ps_w = SLOPE_PS_00;
            2'h1: slope_ps_w = SLOPE_PS_01;
            2'h2: slope_ps_w = SLOPE_PS_10;
            2'h3: begin
                slope_ps_w  = '0;
                slope_unl_w = 1'b1;
            end
        endcase
    end

    // Bandwidth doubles per code step up to 110
    wire [19:0] bw_mhz_w = (bw_code == BW_CODE_LOW) ? BW_MHZ_111
                                                    : BW_MHZ_BASE << bw_code; // R3

    // Gated failure vector
    wire [3:0] fail_vec = {guard_timer_monitor, coarse_freq_monitor,
                           single_cycle_monitor, signal_loss_monitor};
    wire       ref_unavailable = |(fail_vec & gate_bits); // R8

    // Reserved mode code keeps the previous mode; software must not use it
    dpmc_mode_t mode_r;
    dpmc_mode_t mode_nxt;
    assign mode_nxt = (mode_code == MODE_RESERVED) ? mode_r
                                                   : dpmc_mode_t'(mode_code); // R4

    dpmc_state_t state_r;
    dpmc_state_t state_nxt;
    always_comb begin
        unique case (mode_r)
            MODE_FREERUN: state_nxt = ST_FREERUN; // R7
            MODE_FORCED:  state_nxt = ST_HOLDOVER; // R6
            MODE_AUTO: begin
                if (ref_unavailable) begin
                    state_nxt = ST_HOLDOVER; // R5
                end else if (loop_locked) begin
                    state_nxt = ST_LOCKED;
                end else begin
                    state_nxt = ST_ACQUIRE;
                end
            end
            default: state_nxt = state_r;
        endcase
    end

    wire in_hold = state_r == ST_HOLDOVER;
    wire in_lock = state_r == ST_LOCKED;

    // Status read clears; a condition still present sets again, set wins
    wire flags_read = reg_rd && hit_flags;
    always_comb begin
        lock_holdover_flags_nxt = flags_read ? RST_FLAGS : lock_holdover_flags_r; // R15
        if (in_hold) begin
            lock_holdover_flags_nxt[FLAG_HOLD] = 1'b1; // R10
        end
        if (in_lock) begin
            lock_holdover_flags_nxt[FLAG_LOCK] = 1'b1; // R11
        end
    end

    // All registers are single bytes, so no byte ordering applies
    logic [7:0] rd_mux;
    assign rd_mux = hit_loop  ? loop_control :
                    hit_mode  ? operating_mode_select :
                    hit_gate  ? failure_holdover_gate :
                    hit_flags ? lock_holdover_flags_r :
                    hit_pmem  ? phase_memory_limit_code :
                    hit_mon   ? monitor_limit_select : 8'h00; // R14

    always_ff @(posedge core_clk) begin
        if (srst) begin
            mode_r                <= MODE_AUTO;
            state_r               <= ST_ACQUIRE;
            lock_holdover_flags_r <= RST_FLAGS;
        end else if (ce) begin
            mode_r                <= mode_nxt;
            state_r               <= state_nxt;
            lock_holdover_flags_r <= lock_holdover_flags_nxt;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rdata  <= reg_rd ? rd_mux : reg_rdata;
            reg_rvalid <= reg_rd;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            slope_limit_ps  <= SLOPE_PS_00;
            slope_unlimited <= 1'b0;
            loop_bw_mhz     <= BW_MHZ_BASE;
            realign_pulse   <= 1'b0;
        end else if (ce) begin
            slope_limit_ps  <= slope_ps_w;
            slope_unlimited <= slope_unl_w;
            loop_bw_mhz     <= bw_mhz_w;
            realign_pulse   <= realign_req; // R2
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            use_reference        <= 1'b0;
            use_oscillator_input <= 1'b0;
            holdover_active      <= 1'b0;
            locked_active        <= 1'b0;
            phase_mem_code       <= RST_PHASE_MEM;
            monitor_limits       <= RST_MON_LIMIT;
        end else if (ce) begin
            // Reference used only while tracking in automatic mode
            use_reference        <= state_nxt == ST_ACQUIRE || state_nxt == ST_LOCKED; // R5
            use_oscillator_input <= state_nxt == ST_FREERUN; // R7
            holdover_active      <= state_nxt == ST_HOLDOVER; // R6
            locked_active        <= state_nxt == ST_LOCKED;
            phase_mem_code       <= phase_memory_limit_code;
            monitor_limits       <= monitor_limit_select;
        end
    end

    assign mode_applied = mode_r;
endmodule

// File: src/dpmc_pkg.sv
// Behaviour
// R1: Slope code 00/01/10 limits phase rate to 61, 7.5, 0.885 us/s; 11 unlimited.
// R2: Writing realignment bit 4 high aligns output phase to the reference.
// R3: Bandwidth code 000..110 gives 14..896 Hz, code 111 gives 30 mHz.
// R4: Mode 00 freerun, 01 forced holdover, 11 automatic; 10 reserved, never selected.
// R5: Automatic mode locks by reference availability, holdover only when reference unavailable.
// R6: Forced holdover ignores the reference and stays in holdover.
// R7: Freerun derives all outputs from the oscillator input only.
// R8: Low holdover gate bit stops that failure (loss, single cycle, coarse, guard) forcing holdover.
// R9: Software never enables guard bit without single cycle or coarse bit.
// R10: Status bit 0 goes high while in holdover, not maskable.
// R11: Status bit 1 goes high when locked to the reference, not maskable.
// R12: Software writes round(32*log(limit*1e5)) as the phase memory code.
// R13: Software picks a phase memory limit of at least half a reference period.
// R14: Multi-byte registers are big-endian, MSB at the lower address.
// R15: Sticky status bits stay set until software reads the status register.
package dpmc_pkg;
    localparam logic [7:0] OFS_LOOP_CTRL   = 8'h30;
    localparam logic [7:0] OFS_MODE_SEL    = 8'h33;
    localparam logic [7:0] OFS_FAIL_GATE   = 8'h34;
    localparam logic [7:0] OFS_FLAGS       = 8'h44;
    localparam logic [7:0] OFS_PHASE_MEM   = 8'h47;
    localparam logic [7:0] OFS_MON_LIMIT   = 8'h4B;

    localparam logic [7:0] RST_LOOP_CTRL   = 8'h0C;
    localparam logic [7:0] RST_MODE_SEL    = 8'h03;
    localparam logic [7:0] RST_FAIL_GATE   = 8'h87;
    localparam logic [7:0] RST_FLAGS       = 8'h00;
    localparam logic [7:0] RST_PHASE_MEM   = 8'h0A;
    localparam logic [7:0] RST_MON_LIMIT   = 8'h55;

    // Write-select indices of the writable registers
    localparam int NUM_WREG  = 5;
    localparam int WI_LOOP   = 0;
    localparam int WI_MODE   = 1;
    localparam int WI_GATE   = 2;
    localparam int WI_PMEM   = 3;
    localparam int WI_MON    = 4;

    // Field positions
    localparam int SLOPE_LSB   = 2;
    localparam int REALIGN_BIT = 4;
    localparam int BW_LSB      = 5;
    localparam int MODE_LSB    = 0;
    localparam int GATE_LSB    = 0;
    localparam int FLAG_HOLD   = 0;
    localparam int FLAG_LOCK   = 1;

    // Failure gate bit positions within the gate field
    localparam int GATE_SIGNAL_LOSS = 0;
    localparam int GATE_SINGLE_CYC  = 1;
    localparam int GATE_COARSE_FRQ  = 2;
    localparam int GATE_GUARD_TMR   = 3;

    typedef enum logic [1:0] {
        MODE_FREERUN  = 2'h0,
        MODE_FORCED   = 2'h1,
        MODE_RESERVED = 2'h2,
        MODE_AUTO     = 2'h3
    } dpmc_mode_t;

    // Phase slope limits in ps per second
    localparam logic [25:0] SLOPE_PS_00 = 26'h3A2C940; // 61 us/s
    localparam logic [25:0] SLOPE_PS_01 = 26'h07270E0; // 7.5 us/s
    localparam logic [25:0] SLOPE_PS_10 = 26'h00D8108; // 0.885 us/s

    // Loop bandwidth in mHz
    localparam logic [19:0] BW_MHZ_BASE = 20'h036B0;   // 14 Hz, doubles per code
    localparam logic [19:0] BW_MHZ_111  = 20'h0001E;   // 30 mHz
    localparam logic [2:0]  BW_CODE_LOW = 3'h7;
endpackage

// File: src/dpmc_wr_if.sv
`timescale 1ns/1ps
interface dpmc_wr_if;
    logic [dpmc_pkg::NUM_WREG-1:0] wr_sel;
    logic [7:0]                    wr_data;
    logic                          ce;
    modport src (output wr_sel, output wr_data, output ce);
    modport dst (input wr_sel, input wr_data, input ce);
endinterface

// File: src/dpmc_reg_byte.sv
`timescale 1ns/1ps
module dpmc_reg_byte #(
    parameter int         IDX       = 0,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic  core_clk,
    input  wire logic  srst,
    dpmc_wr_if.dst     wr,
    output logic [7:0] value
);
    import dpmc_pkg::*;

    logic [7:0] value_r;
    wire        load_w = wr.ce && wr.wr_sel[IDX];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            value_r <= RESET_VAL;
        end else if (load_w) begin
            value_r <= wr.wr_data;
        end
    end

    assign value = value_r;
endmodule

// File: testbench/dpmc_props.sv
`timescale 1ns/1ps
module dpmc_props
    import dpmc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic        ce,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic [25:0] slope_limit_ps,
    input wire logic        slope_unlimited,
    input wire logic [19:0] loop_bw_mhz,
    input wire logic        realign_pulse,
    input wire logic        use_reference,
    input wire logic        use_oscillator_input,
    input wire logic        holdover_active,
    input wire logic        locked_active,
    input wire dpmc_mode_t  mode_applied
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence rd_flags;
        ce && reg_rd && reg_addr == OFS_FLAGS;
    endsequence
    sequence wr_ctrl;
        ce && reg_wr && reg_addr == OFS_LOOP_CTRL;
    endsequence

    rd_answer_a: assert property (ce && reg_rd |=> reg_rvalid)
        else $error("read not answered");
    rd_single_a: assert property (!(ce && reg_rd) |=> !reg_rvalid)
        else $error("answer without read");
    realign_a: assert property (wr_ctrl ##0 reg_wdata[REALIGN_BIT] |=> realign_pulse)
        else $error("realign pulse missing");
    slope_off_a: assert property (slope_unlimited |-> slope_limit_ps == 26'h0)
        else $error("unlimited slope has a value");
    field_upd_a: assert property (wr_ctrl ##1 ce |=>
        slope_unlimited == (&$past(reg_wdata[3:2], 2)) && loop_bw_mhz ==
        ($past(reg_wdata[7:5], 2) == 3'h7 ? BW_MHZ_111 : BW_MHZ_BASE << $past(reg_wdata[7:5], 2)))
        else $error("loop fields not applied");
    forced_a: assert property ((mode_applied == MODE_FORCED) [*2] |->
        holdover_active && !use_reference)
        else $error("forced holdover not held");
    freerun_a: assert property ((mode_applied == MODE_FREERUN) [*2] |->
        use_oscillator_input && !use_reference && !locked_active)
        else $error("freerun uses reference");
    hold_flag_a: assert property (holdover_active ##2 rd_flags |=> reg_rdata[FLAG_HOLD])
        else $error("holdover flag not set");
    lock_flag_a: assert property (locked_active ##2 rd_flags |=> reg_rdata[FLAG_LOCK])
        else $error("lock flag not set");
endmodule

bind dpmc_top dpmc_props u_props (
    .core_clk(core_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .slope_limit_ps(slope_limit_ps), .slope_unlimited(slope_unlimited),
    .loop_bw_mhz(loop_bw_mhz), .realign_pulse(realign_pulse), .use_reference(use_reference),
    .use_oscillator_input(use_oscillator_input), .holdover_active(holdover_active),
    .locked_active(locked_active), .mode_applied(mode_applied)
);

// File: testbench/dpmc_top_tb_top.sv
`timescale 1ns/1ps
module dpmc_top_tb_top;
    import dpmc_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} dpmc_row_t;
    logic        core_clk, srst, ce, reg_wr, reg_rd, reg_rvalid, loop_locked;
    logic        slope_unlimited, realign_pulse, use_reference, use_oscillator_input;
    logic        holdover_active, locked_active;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, phase_mem_code, monitor_limits, q;
    logic [3:0]  fail;
    logic [25:0] slope_limit_ps;
    logic [19:0] loop_bw_mhz;
    dpmc_mode_t  mode_applied;
    int          errors, samples_checked, cycles;
    dpmc_row_t   rst_tab[6] = '{'{OFS_LOOP_CTRL, 0, RST_LOOP_CTRL}, '{OFS_MODE_SEL, 0, RST_MODE_SEL},
        '{OFS_FAIL_GATE, 0, RST_FAIL_GATE}, '{OFS_FLAGS, 0, RST_FLAGS},
        '{OFS_PHASE_MEM, 0, RST_PHASE_MEM}, '{OFS_MON_LIMIT, 0, RST_MON_LIMIT}};
    // Unmapped and read-only rows must not keep written data
    dpmc_row_t   rows[5] = '{'{OFS_LOOP_CTRL, 8'hEC, 8'hEC}, '{OFS_PHASE_MEM, 8'h5A, 8'h5A},
        '{OFS_MON_LIMIT, 8'h33, 8'h33}, '{8'h31, 8'hAA, 8'h00}, '{OFS_FLAGS, 8'hFF, 8'h00}};

    dpmc_top dut (.core_clk(core_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .signal_loss_monitor(fail[0]), .single_cycle_monitor(fail[1]),
        .coarse_freq_monitor(fail[2]), .guard_timer_monitor(fail[3]), .loop_locked(loop_locked),
        .slope_limit_ps(slope_limit_ps), .slope_unlimited(slope_unlimited),
        .loop_bw_mhz(loop_bw_mhz), .realign_pulse(realign_pulse), .use_reference(use_reference),
        .use_oscillator_input(use_oscillator_input), .holdover_active(holdover_active),
        .locked_active(locked_active), .phase_mem_code(phase_mem_code),
        .monitor_limits(monitor_limits), .mode_applied(mode_applied));

    always #12.5 core_clk = ~core_clk;

    task automatic chk(input string n, input logic [25:0] s, input logic [25:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk("rvalid", reg_rvalid, 1'b1);
        r = reg_rdata;
    endtask

    task automatic settle();
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the tests need
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        {core_clk, ce, reg_wr, reg_rd, reg_addr, reg_wdata, fail} = '0;
        {errors, samples_checked, cycles} = '0;
        srst = 1'b1;
        // Lock held off until the mode tests, so the status register reads clean
        loop_locked = 1'b0;
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        ce <= 1'b1;
        foreach (rst_tab[i]) begin
            rd(rst_tab[i].a, q);
            chk("reset value", q, rst_tab[i].e);
        end
        chk("reset mode", mode_applied, MODE_AUTO);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, q);
            chk("readback", q, rows[i].e);
        end
        chk("phase memory", phase_mem_code, 8'h5A);
        chk("monitor limits", monitor_limits, 8'h33);
        $display("test table done");
        for (int i = 0; i < 8; i++) begin
            wr(OFS_LOOP_CTRL, {i[2:0], 1'b0, i[1:0], 2'b00});
            settle();
            chk("bandwidth", loop_bw_mhz, i == 7 ? BW_MHZ_111 : BW_MHZ_BASE << i);
            chk("unlimited", slope_unlimited, i[1:0] == 2'h3);
            chk("slope", slope_limit_ps, i[1:0] == 0 ? SLOPE_PS_00 : i[1:0] == 1 ? SLOPE_PS_01 :
                i[1:0] == 2 ? SLOPE_PS_10 : 26'h0);
        end
        wr(OFS_LOOP_CTRL, 8'h1C);
        #1 chk("realign", realign_pulse, 1'b1);
        @(posedge core_clk);
        #1 chk("realign end", realign_pulse, 1'b0);
        @(posedge core_clk);
        ce <= 1'b0;
        wr(OFS_PHASE_MEM, 8'h11);
        ce <= 1'b1;
        rd(OFS_PHASE_MEM, q);
        chk("frozen write", q, 8'h5A);
        $display("test loop control done");
        @(posedge core_clk);
        loop_locked <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            wr(OFS_MODE_SEL, 8'(m));
            settle();
            chk("mode", mode_applied, m == 2 ? 1 : m);
            chk("reference use", use_reference, m == 3);
            chk("holdover", holdover_active, m == 1 || m == 2);
            chk("oscillator", use_oscillator_input, m == 0);
            chk("locked", locked_active, m == 3);
        end
        rd(OFS_FLAGS, q);
        chk("lock flag", q[FLAG_LOCK], 1'b1);
        $display("test modes done");
        for (int k = 0; k < 4; k++) begin
            wr(OFS_FAIL_GATE, 8'h80);
            fail <= 4'h1 << k;
            settle();
            chk("masked failure", holdover_active, 1'b0);
            wr(OFS_FAIL_GATE, k == 3 ? 8'h8C : 8'h80 | (8'h01 << k));
            settle();
            chk("gated failure", holdover_active, 1'b1);
            rd(OFS_FLAGS, q);
            chk("hold flag live", q[FLAG_HOLD], 1'b1);
            wr(OFS_MODE_SEL, 8'h00);
            fail <= 4'h0;
            settle();
            rd(OFS_FLAGS, q);
            chk("sticky hold", q[FLAG_HOLD], 1'b1);
            rd(OFS_FLAGS, q);
            chk("hold cleared", q[FLAG_HOLD], 1'b0);
            wr(OFS_MODE_SEL, 8'h03);
            settle();
        end
        $display("test failure gate done");
        conclude();
    end
endmodule
